// ---- logic/token_net_diag_status.sv ----
// diagnostic command register and three status registers of the token controller
//
// Contract
// - start bit runs the selected diagnostic and self-clears on completion
// - command bit one selects the internal ram test
// - command bit two selects the loopback test
// - command bit three selects the dma test
// - command bit seven enables diagnostic mode; zero in network mode
// - status bits zero to three hold the buffer size code
// - length-eight flag set while sending a frame of length eight
// - ack pending set on receive needing reply, cleared when reply sent
// - final frame flag set while sending the last frame of the period
// - send request bit tracks transmitter attempt and the send request pin
// - ring member set after holding and passing the token once
// - mode confirm follows detach request once network state is left
// - token passed flag set on pass, cleared on next received frame
// - resend flag set whenever a frame must be transmitted again
// - ack requested flag set while sending a frame wanting acknowledgement
// - token held set on own token, cleared when passed or ignored
// - receive chain valid mirrors possession of the next receive buffer
// - transmit chain valid mirrors possession of the next frame address
// - status registers are read only; host writes do nothing
`timescale 1ns/1ps

`include "token_net_diag_defs.svh"

module token_net_diag_status (
	input  wire logic                                sys_clk,
	input  wire logic                                rst_n,
	input  wire logic                                host_cs_n,
	input  wire logic                                host_rd_n,
	input  wire logic                                host_wr_n,
	input  wire logic [3:0]                          host_addr,
	input  wire logic [7:0]                          host_data_in,
	output logic      [7:0]                          host_data_out,
	output logic                                     host_data_oe,
	input  wire token_net_diag_pkg::core_event_type  core,
	input  wire logic                                test_done,
	output logic                                     test_go,
	output token_net_diag_pkg::selftest_type         test_sel,
	output logic                                     diagnostic_mode_enable,
	output logic                                     send_request_n
);

	// every piece of state of this block
	typedef struct packed {
		token_net_diag_pkg::host_pins_type pins_s1;
		token_net_diag_pkg::host_pins_type pins_s2;
		logic                              wr_prev;
		token_net_diag_pkg::diag_cmd_type  cmd;
		logic [7:0]                        sr0;
		logic [7:0]                        sr1;
		logic [7:0]                        sr2;
		logic [7:0]                        rdata;
		logic                              oe;
		logic                              sreq_n;
	} bank_reg_type;

	bank_reg_type                      q;
	bank_reg_type                      d;
	token_net_diag_pkg::host_pins_type pins_in;
	logic                              seq_finished;
	logic                              seq_go;
	token_net_diag_pkg::selftest_type  seq_sel;
	// sticky flags: 0 ack pending, 1 member, 2 token passed, 3 resend, 4 token held
	logic [4:0]                        sticky_set;
	logic [4:0]                        sticky_clr;
	logic [4:0]                        sticky_now;
	logic [4:0]                        sticky_next;

	assign pins_in = '{cs_n: host_cs_n, rd_n: host_rd_n, wr_n: host_wr_n,
		addr: host_addr, wdata: host_data_in};

	// test launch and completion tracking
	selftest_sequencer u_seq (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.cmd      (q.cmd),
		.test_done(test_done),
		.test_go  (seq_go),
		.test_sel (seq_sel),
		.finished (seq_finished)
	);

	// present value of each sticky flag
	assign sticky_now[0] = q.sr0[`SR0_ACKPEND_BIT];
	assign sticky_now[1] = q.sr2[`SR2_MEMBER_BIT];
	assign sticky_now[2] = q.sr2[`SR2_TPASSED_BIT];
	assign sticky_now[3] = q.sr2[`SR2_RESEND_BIT];
	assign sticky_now[4] = q.sr2[`SR2_THELD_BIT];

	// reply needed sets, reply sent clears
	assign sticky_set[0] = core.rx_need_ack;
	assign sticky_clr[0] = core.ack_reply_sent;
	// a pass while holding the token joins the ring; detach leaves it
	assign sticky_set[1] = core.token_passed & q.sr2[`SR2_THELD_BIT];
	assign sticky_clr[1] = core.detach_request;
	// pass sets, next received frame clears
	assign sticky_set[2] = core.token_passed;
	assign sticky_clr[2] = core.frame_received;
	// resend sets, a fresh token starts a clean period
	assign sticky_set[3] = core.resend;
	assign sticky_clr[3] = core.token_for_me;
	// own token sets, pass or ignore clears
	assign sticky_set[4] = core.token_for_me;
	assign sticky_clr[4] = core.token_passed | core.token_ignored;

	// one update per flag; a set in the cycle of its clear wins, so no event is lost
	generate
		for (genvar gi = 0; gi < 5; gi++) begin : g_sticky
			assign sticky_next[gi] = sticky_set[gi] | (sticky_now[gi] & ~sticky_clr[gi]);
		end
	endgenerate

	// next value of every register
	always_comb begin
		logic       wr_active;
		logic       wr_edge;
		logic       rd_active;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic [7:0] cmd_byte;
		wr_active = 1'b0;
		wr_edge = 1'b0;
		rd_active = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		cmd_byte = 8'h00;
		d = q;

		// host pins are asynchronous, two flops before any use
		d.pins_s1 = pins_in;
		d.pins_s2 = q.pins_s1;
		addr = q.pins_s2.addr;
		wdata = q.pins_s2.wdata;
		wr_active = !q.pins_s2.cs_n && !q.pins_s2.wr_n;
		rd_active = !q.pins_s2.cs_n && !q.pins_s2.rd_n;
		// one write per strobe: act on its leading edge only
		wr_edge = wr_active && !q.wr_prev;
		d.wr_prev = wr_active;

		if (seq_finished) begin
			d.cmd.start_selftest = 1'b0;
		end

		// host write to the command register; it wins over completion
		if (wr_edge && addr == `ADDR_DIAG_COMMAND) begin
			d.cmd.diagnostic_mode_enable = wdata[`CMD_DIAG_EN_BIT];
			d.cmd.ram_test_select = wdata[`CMD_RAM_BIT];
			d.cmd.wrap_test_select = wdata[`CMD_WRAP_BIT];
			d.cmd.dma_test_select = wdata[`CMD_DMA_BIT];
			// start only takes effect in diagnostic mode
			d.cmd.start_selftest = wdata[`CMD_START_BIT] & wdata[`CMD_DIAG_EN_BIT];
		end
		// writes to status offsets fall through untouched

		// pin driven from the transmitter attempt, low is active
		d.sreq_n = ~core.tx_attempt;

		// frame status register
		d.sr0 = `STATUS_RESET;
		// buffer size code, buffer is (n+1) x 64 bytes
		d.sr0[`SR0_SIZE_MSB:`SR0_SIZE_LSB] = core.buffer_size_code;
		d.sr0[`SR0_LEN8_BIT] = core.tx_active & core.frame_len_eight;
		// ack pending, a new request wins over the clear
		d.sr0[`SR0_ACKPEND_BIT] = sticky_next[0];
		// last frame of this access period
		d.sr0[`SR0_FINAL_BIT] = core.tx_active & core.final_frame;

		// link status register; bits four to zero stay zero
		d.sr1 = `STATUS_RESET;
		d.sr1[`SR1_RXIDLE_BIT] = core.receiver_idle;
		// bit shows the pin level, reads low while sending
		d.sr1[`SR1_SENDREQ_BIT] = q.sreq_n;
		d.sr1[`SR1_TAEXP_BIT] = core.ack_timer_expired;

		// ring status register
		// membership needs a pass while holding the token
		d.sr2[`SR2_MEMBER_BIT] = sticky_next[1];
		// confirm only once the core has really gone quiet
		d.sr2[`SR2_CONFIRM_BIT] = core.detach_request & core.network_quiet;
		// token passed, next received frame clears it
		d.sr2[`SR2_TPASSED_BIT] = sticky_next[2];
		// resend, cleared when a new token starts a fresh period
		d.sr2[`SR2_RESEND_BIT] = sticky_next[3];
		// acknowledgement wanted for the frame being sent
		d.sr2[`SR2_ACKREQ_BIT] = core.tx_active & core.ack_wanted;
		// token held until passed or ignored
		d.sr2[`SR2_THELD_BIT] = sticky_next[4];
		d.sr2[`SR2_RXCHAIN_BIT] = core.rx_chain_valid;
		d.sr2[`SR2_TXCHAIN_BIT] = core.tx_chain_valid;

		// reserved command bits six to four read as zero
		cmd_byte = {q.cmd.diagnostic_mode_enable, 3'b000, q.cmd.dma_test_select,
			q.cmd.wrap_test_select, q.cmd.ram_test_select, q.cmd.start_selftest};

		// read mux; unmapped offsets read zero
		d.oe = rd_active;
		if (rd_active) begin
			case (addr)
				`ADDR_DIAG_COMMAND: begin
					d.rdata = cmd_byte;
				end
				`ADDR_FRAME_STATUS: begin
					d.rdata = q.sr0;
				end
				`ADDR_LINK_STATUS: begin
					d.rdata = q.sr1;
				end
				`ADDR_RING_STATUS: begin
					d.rdata = q.sr2;
				end
				default: begin
					d.rdata = `READ_DATA_RESET;
				end
			endcase
		end else begin
			d.rdata = `READ_DATA_RESET;
		end
	end

	// single register stage for all state
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.pins_s1 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, wdata: 8'h00};
			q.pins_s2 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, wdata: 8'h00};
			q.cmd <= 5'h00;
			q.sr0 <= `STATUS_RESET;
			q.sr1 <= `STATUS_RESET;
			q.sr2 <= `STATUS_RESET;
			q.rdata <= `READ_DATA_RESET;
			q.sreq_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign host_data_out = q.rdata;
	assign host_data_oe = q.oe;
	assign diagnostic_mode_enable = q.cmd.diagnostic_mode_enable;
	assign send_request_n = q.sreq_n;
	assign test_go = seq_go;
	assign test_sel = seq_sel;

endmodule

// ---- logic/token_net_diag_defs.svh ----
// register offsets, bit positions and reset values of the diagnostic and status bank
`ifndef TOKEN_NET_DIAG_DEFS_SVH
`define TOKEN_NET_DIAG_DEFS_SVH

// host register offsets on the four address lines
`define ADDR_DIAG_COMMAND     4'h1
`define ADDR_FRAME_STATUS     4'h2
`define ADDR_LINK_STATUS      4'h3
`define ADDR_RING_STATUS      4'h4

// command register bit positions
`define CMD_START_BIT         0
`define CMD_RAM_BIT           1
`define CMD_WRAP_BIT          2
`define CMD_DMA_BIT           3
`define CMD_DIAG_EN_BIT       7

// frame status bit positions
`define SR0_SIZE_LSB          0
`define SR0_SIZE_MSB          3
`define SR0_LEN8_BIT          5
`define SR0_ACKPEND_BIT       6
`define SR0_FINAL_BIT         7

// link status bit positions
`define SR1_RXIDLE_BIT        5
`define SR1_SENDREQ_BIT       6
`define SR1_TAEXP_BIT         7

// ring status bit positions
`define SR2_MEMBER_BIT        0
`define SR2_CONFIRM_BIT       1
`define SR2_TPASSED_BIT       2
`define SR2_RESEND_BIT        3
`define SR2_ACKREQ_BIT        4
`define SR2_THELD_BIT         5
`define SR2_RXCHAIN_BIT       6
`define SR2_TXCHAIN_BIT       7

// reset values
`define DIAG_COMMAND_RESET    8'h00
`define STATUS_RESET          8'h00
`define READ_DATA_RESET       8'h00

`endif

// ---- logic/token_net_diag_pkg.sv ----
// types shared by the diagnostic command and status bank
package token_net_diag_pkg;

	typedef enum logic [2:0] {
		TEST_NONE = 3'b000,
		TEST_RAM  = 3'b001,
		TEST_WRAP = 3'b010,
		TEST_DMA  = 3'b011,
		TEST_IRQ  = 3'b100
	} selftest_type;

	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b00,
		SEQ_LAUNCH = 2'b01,
		SEQ_WAIT   = 2'b10,
		SEQ_FINISH = 2'b11
	} seq_state_type;

	// host bus pins as seen after sampling
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [3:0] addr;
		logic [7:0] wdata;
	} host_pins_type;

	// live state reported by the controller core, same clock
	typedef struct packed {
		logic       tx_active;
		logic       frame_len_eight;
		logic       final_frame;
		logic       ack_wanted;
		logic       tx_attempt;
		logic       rx_need_ack;
		logic       ack_reply_sent;
		logic       token_for_me;
		logic       token_passed;
		logic       token_ignored;
		logic       frame_received;
		logic       resend;
		logic       receiver_idle;
		logic       ack_timer_expired;
		logic       rx_chain_valid;
		logic       tx_chain_valid;
		logic       detach_request;
		logic       network_quiet;
		logic [3:0] buffer_size_code;
	} core_event_type;

	// command register content that is kept
	typedef struct packed {
		logic diagnostic_mode_enable;
		logic dma_test_select;
		logic wrap_test_select;
		logic ram_test_select;
		logic start_selftest;
	} diag_cmd_type;

endpackage

// ---- logic/selftest_sequencer.sv ----
// launches one self-test and reports its completion
`timescale 1ns/1ps

module selftest_sequencer (
	input  wire logic                              sys_clk,
	input  wire logic                              rst_n,
	input  wire token_net_diag_pkg::diag_cmd_type  cmd,
	input  wire logic                              test_done,
	output logic                                   test_go,
	output token_net_diag_pkg::selftest_type       test_sel,
	output logic                                   finished
);

	typedef struct packed {
		token_net_diag_pkg::seq_state_type state;
		token_net_diag_pkg::selftest_type  sel;
		logic                              go;
		logic                              fin;
	} seq_reg_type;

	seq_reg_type q;
	seq_reg_type d;
	logic        armed;

	assign armed = cmd.diagnostic_mode_enable & cmd.start_selftest;

	// next-state; leaving diagnostic mode aborts a running test
	always_comb begin
		d = q;
		d.go = 1'b0;
		d.fin = 1'b0;
		case (q.state)
			token_net_diag_pkg::SEQ_IDLE: begin
				// pick the selected test; the start bit still reads set in the
				// cycle the finish pulse is out, so that cycle must not relaunch
				if (armed && !q.fin) begin
					if (cmd.ram_test_select) begin
						d.sel = token_net_diag_pkg::TEST_RAM;
					end else if (cmd.wrap_test_select) begin
						d.sel = token_net_diag_pkg::TEST_WRAP;
					end else if (cmd.dma_test_select) begin
						d.sel = token_net_diag_pkg::TEST_DMA;
					end else begin
						d.sel = token_net_diag_pkg::TEST_IRQ;
					end
					d.state = token_net_diag_pkg::SEQ_LAUNCH;
				end
			end
			token_net_diag_pkg::SEQ_LAUNCH: begin
				d.go = 1'b1;
				d.state = token_net_diag_pkg::SEQ_WAIT;
			end
			token_net_diag_pkg::SEQ_WAIT: begin
				if (test_done || !cmd.diagnostic_mode_enable) begin
					d.state = token_net_diag_pkg::SEQ_FINISH;
				end
			end
			token_net_diag_pkg::SEQ_FINISH: begin
				d.fin = 1'b1;
				d.sel = token_net_diag_pkg::TEST_NONE;
				d.state = token_net_diag_pkg::SEQ_IDLE;
			end
			default: begin
				d.state = token_net_diag_pkg::SEQ_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '{state: token_net_diag_pkg::SEQ_IDLE,
				sel: token_net_diag_pkg::TEST_NONE, go: 1'b0, fin: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign test_go = q.go;
	assign test_sel = q.sel;
	assign finished = q.fin;

endmodule

// ---- verification/token_net_diag_status_monitor.sv ----
// port assertions for the diagnostic command and status bank
`timescale 1ns/1ps

module token_net_diag_status_monitor (
	input wire logic                                sys_clk,
	input wire logic                                rst_n,
	input wire logic                                host_cs_n,
	input wire logic                                host_rd_n,
	input wire logic [7:0]                          host_data_out,
	input wire logic                                host_data_oe,
	input wire token_net_diag_pkg::core_event_type  core,
	input wire logic                                test_done,
	input wire logic                                test_go,
	input wire token_net_diag_pkg::selftest_type    test_sel,
	input wire logic                                diagnostic_mode_enable,
	input wire logic                                send_request_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	launch_after_sel_a: assert property (
		$past(test_sel) == 3'h0 && test_sel != 3'h0 |=> test_go) else $error("no launch pulse");
	launch_pulse_a: assert property (test_go |=> !test_go) else $error("launch too long");
	sel_hold_a: assert property (
		test_sel != 3'h0 && !test_done && !$past(test_done) && !$past(test_done, 2)
		&& !$past(test_done, 3) && diagnostic_mode_enable |=> $stable(test_sel))
		else $error("selection moved mid-test");
	sel_clear_a: assert property (
		test_done && test_sel != 3'h0 |-> ##[1:3] test_sel == 3'h0) else $error("test not ended");
	launch_diag_a: assert property (test_go |-> diagnostic_mode_enable)
		else $error("launch outside diagnostic mode");
	send_req_a: assert property ($past(rst_n) |-> send_request_n == !$past(core.tx_attempt))
		else $error("send request pin wrong");
	// data bus quiet when not driven
	idle_bus_a: assert property (!host_data_oe |-> host_data_out == 8'h00)
		else $error("data out while idle");
	read_answer_a: assert property ($fell(host_cs_n | host_rd_n) |-> ##[1:4] host_data_oe)
		else $error("read not answered");
endmodule

bind token_net_diag_status token_net_diag_status_monitor u_mon (
	.sys_clk(sys_clk), .rst_n(rst_n), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
	.host_data_out(host_data_out), .host_data_oe(host_data_oe), .core(core),
	.test_done(test_done), .test_go(test_go), .test_sel(test_sel),
	.diagnostic_mode_enable(diagnostic_mode_enable), .send_request_n(send_request_n)
);

// ---- verification/host_bus_model.sv ----
// host processor model on the parallel register bus
`timescale 1ns/1ps

module host_bus_model (
	input wire logic        sys_clk,
	output logic            host_cs_n,
	output logic            host_rd_n,
	output logic            host_wr_n,
	output logic [3:0]      host_addr,
	output logic [7:0]      host_data_in,
	input wire logic [7:0]  host_data_out,
	input wire logic        host_data_oe
);
	initial begin
		host_cs_n = 1'h1;
		host_rd_n = 1'h1;
		host_wr_n = 1'h1;
		host_addr = 4'h0;
		host_data_in = 8'h00;
	end
	// strobes stay high long enough for the synchronisers to see a gap
	task automatic gap();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	// write held past the two-flop sync delay
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		gap();
		host_addr = a;
		host_data_in = d;
		host_cs_n = 1'h0;
		host_wr_n = 1'h0;
		repeat (5) @(posedge sys_clk);
		#1;
		host_cs_n = 1'h1;
		host_wr_n = 1'h1;
		host_data_in = ~d; // released bus does not keep its value
	endtask
	// read held until the block answers, bounded
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output bit to);
		int n;
		gap();
		host_addr = a;
		host_cs_n = 1'h0;
		host_rd_n = 1'h0;
		to = 1'b1;
		d = 8'h00;
		for (n = 0; n < 12 && to; n++) begin
			@(posedge sys_clk);
			if (host_data_oe === 1'h1) begin
				d = host_data_out;
				to = 1'b0;
			end
		end
		#1;
		host_cs_n = 1'h1;
		host_rd_n = 1'h1;
	endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the diagnostic command and status bank
`timescale 1ns/1ps
`include "token_net_diag_defs.svh"

module tb_top;
	logic                                sys_clk;
	logic                                rst_n;
	logic                                host_cs_n;
	logic                                host_rd_n;
	logic                                host_wr_n;
	logic [3:0]                          host_addr;
	logic [7:0]                          host_data_in;
	logic [7:0]                          host_data_out;
	logic                                host_data_oe;
	token_net_diag_pkg::core_event_type  core;
	logic                                test_done;
	logic                                test_go;
	token_net_diag_pkg::selftest_type    test_sel;
	logic                                diagnostic_mode_enable;
	logic                                send_request_n;
	int                                  failures;
	int                                  samples_checked;
	int                                  seed;
	int                                  gos;
	int                                  n;
	logic [31:0]                         r;
	logic [7:0]                          e;
	logic [7:0]                          v;
	logic [23:0]                         e3;
	bit                                  to;
	// pulse steps: core bit, register offset, expected value
	logic [23:0] st [8] = '{24'h0e0420, 24'h0a0428, 24'h0d040d, 24'h0b0409,
		24'h0e0421, 24'h0c0401, 24'h100240, 24'h0f0200};

	token_net_diag_status DUT (.sys_clk(sys_clk), .rst_n(rst_n), .host_cs_n(host_cs_n),
		.host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .core(core), .test_done(test_done), .test_go(test_go),
		.test_sel(test_sel), .diagnostic_mode_enable(diagnostic_mode_enable),
		.send_request_n(send_request_n));
	host_bus_model host (.sys_clk(sys_clk), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .host_addr(host_addr), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe));

	// 40 MHz clock
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// launch pulses are counted as they come, so none is missed mid-write
	always @(posedge sys_clk) if (test_go === 1'h1) gos++;

	task automatic end_of_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] s);
		samples_checked++;
		if (s !== x) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] x);
		host.rd(a, v, to);
		if (to) begin
			failures++;
			$display("CHECK FAILED %s expected answer seen timeout", nm);
			end_of_test();
		end else
			chk(nm, x, v);
	endtask
	function automatic token_net_diag_pkg::selftest_type pick(input logic [2:0] s);
		if (s[0]) return token_net_diag_pkg::TEST_RAM;
		if (s[1]) return token_net_diag_pkg::TEST_WRAP;
		if (s[2]) return token_net_diag_pkg::TEST_DMA;
		return token_net_diag_pkg::TEST_IRQ;
	endfunction
	// level status bits of all three status registers, sticky flags clear
	function automatic logic [23:0] lvl(input token_net_diag_pkg::core_event_type c);
		return {c.final_frame, 1'h0, c.frame_len_eight, 1'h0, c.buffer_size_code,
			c.ack_timer_expired, ~c.tx_attempt, c.receiver_idle, 5'h00,
			c.tx_chain_valid, c.rx_chain_valid, 1'h0, c.ack_wanted, 2'h0,
			c.detach_request & c.network_quiet, 1'h0};
	endfunction

	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		end_of_test();
	end

	initial begin
		seed = 32'hd5f860fd;
		rst_n = 1'h0;
		test_done = 1'h0;
		core = '0;
		repeat (12) @(posedge sys_clk);
		#1 rst_n = 1'h1;
		// reset values, unmapped and unused bits
		for (int i = 0; i < 5; i++) rdchk("reset", 4'(i), i == 3 ? 8'h40 : 8'h00);
		for (int i = 2; i < 5; i++) begin
			host.wr(4'(i), 8'hff);
			rdchk("read only", 4'(i), i == 3 ? 8'h40 : 8'h00);
		end
		host.wr(`ADDR_DIAG_COMMAND, 8'h01);
		repeat (8) @(posedge sys_clk);
		chk("launches", 8'h00, 8'(gos));
		chk("diag enable", 8'h00, {7'h00, diagnostic_mode_enable});
		rdchk("command", `ADDR_DIAG_COMMAND, 8'h00);
		// each selection launches, runs and self-clears
		for (int s = 0; s < 8; s++) begin
			r = $random(seed);
			e = {1'h1, 3'h0, 3'(s), 1'h0};
			// selection loaded before the start bit
			host.wr(`ADDR_DIAG_COMMAND, {1'h1, r[6:4], 3'(s), 1'h0});
			n = gos;
			host.wr(`ADDR_DIAG_COMMAND, {1'h1, r[6:4], 3'(s), 1'h1});
			repeat (4) @(posedge sys_clk);
			#1;
			chk("launches", 8'h01, 8'(gos - n));
			chk("test_sel", 8'(pick(3'(s))), 8'(test_sel));
			chk("diag enable", 8'h01, {7'h00, diagnostic_mode_enable});
			rdchk("command running", `ADDR_DIAG_COMMAND, e | 8'h01);
			test_done = 1'h1;
			@(posedge sys_clk);
			#1 test_done = 1'h0;
			rdchk("command done", `ADDR_DIAG_COMMAND, e);
			chk("test_sel idle", 8'h00, 8'(test_sel));
		end
		// leaving diagnostic mode aborts a running test
		host.wr(`ADDR_DIAG_COMMAND, 8'h82);
		n = gos;
		host.wr(`ADDR_DIAG_COMMAND, 8'h83);
		repeat (4) @(posedge sys_clk);
		#1;
		chk("test_sel abort", 8'(token_net_diag_pkg::TEST_RAM), 8'(test_sel));
		host.wr(`ADDR_DIAG_COMMAND, 8'h00);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("launches abort", 8'h01, 8'(gos - n));
		chk("test_sel aborted", 8'h00, 8'(test_sel));
		// random level status with the transmitter busy, size corners first
		for (int k = 0; k < 12; k++) begin
			core = 22'(($random(seed) & 32'h3e03ff) | 32'h200000);
			if (k < 2) core.buffer_size_code = k ? 4'h0 : 4'hf;
			e3 = lvl(core);
			rdchk("frame_status_zero", `ADDR_FRAME_STATUS, e3[23:16]);
			rdchk("link_status_one", `ADDR_LINK_STATUS, e3[15:8]);
			chk("send_request_n", {7'h00, ~core.tx_attempt}, {7'h00, send_request_n});
			rdchk("ring_status_two", `ADDR_RING_STATUS, e3[7:0]);
		end
		core = '0;
		foreach (st[i]) begin
			@(posedge sys_clk);
			#1 core[st[i][20:16]] = 1'h1;
			@(posedge sys_clk);
			#1 core[st[i][20:16]] = 1'h0;
			rdchk("flag sequence", st[i][11:8], st[i][7:0]);
		end
		end_of_test();
	end
endmodule
